// >>> hdl/window_threshold_defs.vh
// Offsets, field positions, reset values for the window threshold bank
// Assumes an 8-bit register port with byte offsets as below
`ifndef WINDOW_THRESHOLD_DEFS_VH
`define WINDOW_THRESHOLD_DEFS_VH
`define OFF_COMPARE_ENABLE 8'h37
`define OFF_CH0_HI_LO 8'h38
`define OFF_CH0_HI_UP 8'h39
`define OFF_CH0_LO_LO 8'h3A
`define OFF_CH0_LO_UP 8'h3B
`define OFF_CH1_HI_LO 8'h3C
`define OFF_CH1_HI_UP 8'h3D
`define OFF_CH1_LO_LO 8'h3E
`define OFF_CH1_LO_UP 8'h3F
`define OFF_CH0_HYST 8'h40
`define OFF_CH1_HYST 8'h41
`define OFF_IRQ_STATUS 8'h50
`define OFF_IRQ_ENABLE 8'h51
`define OFF_IRQ_CLEAR 8'h52
`define NIBBLE_MSB 3
`define HYST_MSB 5
`define RESET_BYTE 8'h00
`define RESET_NIBBLE 4'h0
`define RESET_HYST 6'h00
`endif

// >>> hdl/window_channel_compare.v
// One channel of the window comparator with hysteresis on both sides
// Assumes sample_valid is a one-cycle pulse on clk with a stable result
module window_channel_compare #(
    parameter WIDTH = 12,
    parameter HW = 6
) (
    input wire clk,
    input wire rst_n,
    input wire enable,
    input wire sample_valid,
    input wire [WIDTH-1:0] result,
    input wire [WIDTH-1:0] high_limit,
    input wire [WIDTH-1:0] low_limit,
    input wire [HW-1:0] hysteresis,
    output reg high_q,
    output reg low_q
);
    // One extra bit keeps limit +/- hysteresis from wrapping
    wire [WIDTH:0] high_release;
    wire [WIDTH:0] low_release;
    wire [WIDTH:0] res_x;
    reg high_d;
    reg low_d;
    assign res_x = {1'b0, result};
    assign high_release = {1'b0, high_limit} - {{(WIDTH+1-HW){1'b0}}, hysteresis};
    assign low_release = {1'b0, low_limit} + {{(WIDTH+1-HW){1'b0}}, hysteresis};

    always @* begin
        high_d = high_q;
        low_d = low_q;
        if (!enable) begin
            high_d = 1'b0;
            low_d = 1'b0;
        end else if (sample_valid) begin
            if (result >= high_limit) begin
                high_d = 1'b1;
            end else if (!high_release[WIDTH] && res_x < high_release) begin
                high_d = 1'b0;
            end
            if (result <= low_limit) begin
                low_d = 1'b1;
            end else if (res_x > low_release) begin
                low_d = 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            high_q <= 1'b0;
            low_q <= 1'b0;
        end else begin
            high_q <= high_d;
            low_q <= low_d;
        end
    end
endmodule

// >>> hdl/window_threshold_registers.v
// Threshold, hysteresis and enable registers of a two-channel window comparator
// Assumes conversion results and their valid strobe arrive on clk
// Assumes the host never raises both strobes in one cycle
// Limit bytes act as written; no shadowing of the 12-bit pair
//
// The plain strobed port was chosen for this implementation.
`include "window_threshold_defs.vh"
module window_threshold_registers #(
    parameter WIDTH = 12
) (
    input wire clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    input wire sample_valid,
    input wire sample_channel,
    input wire [WIDTH-1:0] sample_result,
    output reg ch0_high_q,
    output reg ch0_low_q,
    output reg ch1_high_q,
    output reg ch1_low_q,
    output reg irq_q
);
    reg window_compare_enable_q;
    reg [7:0] chan0_high_limit_low_byte_q;
    reg [3:0] chan0_high_limit_high_nibble_q;
    reg [7:0] chan0_low_limit_low_byte_q;
    reg [3:0] chan0_low_limit_high_nibble_q;
    reg [7:0] chan1_high_limit_low_byte_q;
    reg [3:0] chan1_high_limit_high_nibble_q;
    reg [7:0] chan1_low_limit_low_byte_q;
    reg [3:0] chan1_low_limit_high_nibble_q;
    reg [5:0] chan0_hysteresis_value_q;
    reg [5:0] chan1_hysteresis_value_q;
    reg [3:0] irq_status_q;
    reg [3:0] irq_enable_q;
    reg [7:0] rdata_d;
    wire [WIDTH-1:0] ch0_high_limit;
    wire [WIDTH-1:0] ch0_low_limit;
    wire [WIDTH-1:0] ch1_high_limit;
    wire [WIDTH-1:0] ch1_low_limit;
    wire c0h;
    wire c0l;
    wire c1h;
    wire c1l;
    wire [3:0] rise;
    wire [3:0] clear_bits;
    wire [3:0] compare_d;
    wire [3:0] compare_q;
    wire ch0_sample;
    wire ch1_sample;
    // Per-register write strobes
    wire enable_we;
    wire ch0_hi_lo_we;
    wire ch0_hi_up_we;
    wire ch0_lo_lo_we;
    wire ch0_lo_up_we;
    wire ch1_hi_lo_we;
    wire ch1_hi_up_we;
    wire ch1_lo_lo_we;
    wire ch1_lo_up_we;
    wire ch0_hyst_we;
    wire ch1_hyst_we;
    wire irq_enable_we;
    wire irq_clear_we;
    reg [3:0] irq_status_d;
    reg irq_d;

    assign ch0_high_limit = {chan0_high_limit_high_nibble_q, chan0_high_limit_low_byte_q};
    assign ch0_low_limit = {chan0_low_limit_high_nibble_q, chan0_low_limit_low_byte_q};
    assign ch1_high_limit = {chan1_high_limit_high_nibble_q, chan1_high_limit_low_byte_q};
    assign ch1_low_limit = {chan1_low_limit_high_nibble_q, chan1_low_limit_low_byte_q};

    function wr_hit;
        input [7:0] a;
        input [7:0] off;
        begin
            wr_hit = (a == off);
        end
    endfunction

    function [7:0] pad_nibble;
        input [3:0] n;
        begin
            pad_nibble = {4'h0, n};
        end
    endfunction

    function [7:0] pad_hyst;
        input [5:0] h;
        begin
            pad_hyst = {2'h0, h};
        end
    endfunction

    // One strobe per register except the read-only status; unmapped offsets match none
    assign enable_we = reg_wr && wr_hit(reg_addr, `OFF_COMPARE_ENABLE);
    assign ch0_hi_lo_we = reg_wr && wr_hit(reg_addr, `OFF_CH0_HI_LO);
    assign ch0_hi_up_we = reg_wr && wr_hit(reg_addr, `OFF_CH0_HI_UP);
    assign ch0_lo_lo_we = reg_wr && wr_hit(reg_addr, `OFF_CH0_LO_LO);
    assign ch0_lo_up_we = reg_wr && wr_hit(reg_addr, `OFF_CH0_LO_UP);
    assign ch1_hi_lo_we = reg_wr && wr_hit(reg_addr, `OFF_CH1_HI_LO);
    assign ch1_hi_up_we = reg_wr && wr_hit(reg_addr, `OFF_CH1_HI_UP);
    assign ch1_lo_lo_we = reg_wr && wr_hit(reg_addr, `OFF_CH1_LO_LO);
    assign ch1_lo_up_we = reg_wr && wr_hit(reg_addr, `OFF_CH1_LO_UP);
    assign ch0_hyst_we = reg_wr && wr_hit(reg_addr, `OFF_CH0_HYST);
    assign ch1_hyst_we = reg_wr && wr_hit(reg_addr, `OFF_CH1_HYST);
    assign irq_enable_we = reg_wr && wr_hit(reg_addr, `OFF_IRQ_ENABLE);
    assign irq_clear_we = reg_wr && wr_hit(reg_addr, `OFF_IRQ_CLEAR);

    always @(posedge clk) begin
        if (!rst_n) begin
            window_compare_enable_q <= 1'b0;
        end else if (enable_we) begin
            window_compare_enable_q <= reg_wdata[0];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan0_high_limit_low_byte_q <= `RESET_BYTE;
        end else if (ch0_hi_lo_we) begin
            chan0_high_limit_low_byte_q <= reg_wdata;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan0_high_limit_high_nibble_q <= `RESET_NIBBLE;
        end else if (ch0_hi_up_we) begin
            chan0_high_limit_high_nibble_q <= reg_wdata[`NIBBLE_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan0_low_limit_low_byte_q <= `RESET_BYTE;
        end else if (ch0_lo_lo_we) begin
            chan0_low_limit_low_byte_q <= reg_wdata;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan0_low_limit_high_nibble_q <= `RESET_NIBBLE;
        end else if (ch0_lo_up_we) begin
            chan0_low_limit_high_nibble_q <= reg_wdata[`NIBBLE_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan1_high_limit_low_byte_q <= `RESET_BYTE;
        end else if (ch1_hi_lo_we) begin
            chan1_high_limit_low_byte_q <= reg_wdata;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan1_high_limit_high_nibble_q <= `RESET_NIBBLE;
        end else if (ch1_hi_up_we) begin
            chan1_high_limit_high_nibble_q <= reg_wdata[`NIBBLE_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan1_low_limit_low_byte_q <= `RESET_BYTE;
        end else if (ch1_lo_lo_we) begin
            chan1_low_limit_low_byte_q <= reg_wdata;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan1_low_limit_high_nibble_q <= `RESET_NIBBLE;
        end else if (ch1_lo_up_we) begin
            chan1_low_limit_high_nibble_q <= reg_wdata[`NIBBLE_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan0_hysteresis_value_q <= `RESET_HYST;
        end else if (ch0_hyst_we) begin
            chan0_hysteresis_value_q <= reg_wdata[`HYST_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan1_hysteresis_value_q <= `RESET_HYST;
        end else if (ch1_hyst_we) begin
            chan1_hysteresis_value_q <= reg_wdata[`HYST_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            irq_enable_q <= 4'h0;
        end else if (irq_enable_we) begin
            irq_enable_q <= reg_wdata[3:0];
        end
    end

    // Each channel only sees its own conversions
    assign ch0_sample = sample_valid && !sample_channel;
    assign ch1_sample = sample_valid && sample_channel;
    window_channel_compare #(.WIDTH(WIDTH), .HW(6)) u_ch0 (
        .clk(clk),
        .rst_n(rst_n),
        .enable(window_compare_enable_q),
        .sample_valid(ch0_sample),
        .result(sample_result),
        .high_limit(ch0_high_limit),
        .low_limit(ch0_low_limit),
        .hysteresis(chan0_hysteresis_value_q),
        .high_q(c0h),
        .low_q(c0l)
    );

    window_channel_compare #(.WIDTH(WIDTH), .HW(6)) u_ch1 (
        .clk(clk),
        .rst_n(rst_n),
        .enable(window_compare_enable_q),
        .sample_valid(ch1_sample),
        .result(sample_result),
        .high_limit(ch1_high_limit),
        .low_limit(ch1_low_limit),
        .hysteresis(chan1_hysteresis_value_q),
        .high_q(c1h),
        .low_q(c1l)
    );

    assign compare_d = {c1l, c1h, c0l, c0h} & {4{window_compare_enable_q}};
    assign compare_q = {ch1_low_q, ch1_high_q, ch0_low_q, ch0_high_q};
    // Gated edges, so no event without an output rise
    assign rise = compare_d & ~compare_q;
    assign clear_bits = irq_clear_we ? reg_wdata[3:0] : 4'h0;

    // Set beats clear in the same cycle
    always @* begin
        irq_status_d = (irq_status_q & ~clear_bits) | rise;
        irq_d = |(irq_status_d & irq_enable_q);
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            ch0_high_q <= 1'b0;
            ch0_low_q <= 1'b0;
        end else begin
            ch0_high_q <= compare_d[0];
            ch0_low_q <= compare_d[1];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            ch1_high_q <= 1'b0;
            ch1_low_q <= 1'b0;
        end else begin
            ch1_high_q <= compare_d[2];
            ch1_low_q <= compare_d[3];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            irq_status_q <= 4'h0;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    // Built from next status, so no extra cycle of lag
    always @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Unmapped and write-only offsets read zero
    always @* begin
        rdata_d = 8'h00;
        case (reg_addr)
            `OFF_COMPARE_ENABLE: rdata_d = {7'h00, window_compare_enable_q};
            `OFF_CH0_HI_LO: rdata_d = chan0_high_limit_low_byte_q;
            `OFF_CH0_HI_UP: rdata_d = pad_nibble(chan0_high_limit_high_nibble_q);
            `OFF_CH0_LO_LO: rdata_d = chan0_low_limit_low_byte_q;
            `OFF_CH0_LO_UP: rdata_d = pad_nibble(chan0_low_limit_high_nibble_q);
            `OFF_CH1_HI_LO: rdata_d = chan1_high_limit_low_byte_q;
            `OFF_CH1_HI_UP: rdata_d = pad_nibble(chan1_high_limit_high_nibble_q);
            `OFF_CH1_LO_LO: rdata_d = chan1_low_limit_low_byte_q;
            `OFF_CH1_LO_UP: rdata_d = pad_nibble(chan1_low_limit_high_nibble_q);
            `OFF_CH0_HYST: rdata_d = pad_hyst(chan0_hysteresis_value_q);
            `OFF_CH1_HYST: rdata_d = pad_hyst(chan1_hysteresis_value_q);
            `OFF_IRQ_STATUS: rdata_d = pad_nibble(irq_status_q);
            `OFF_IRQ_ENABLE: rdata_d = pad_nibble(irq_enable_q);
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data valid only the cycle after the strobe
    always @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end
endmodule

// >>> verif/window_threshold_chk.sv
// Concurrent checks for the window threshold register bank
// Assumes it is bound to the top module and sees only its ports
module window_threshold_chk #(
    parameter WIDTH = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic sample_valid,
    input wire logic sample_channel,
    input wire logic [WIDTH-1:0] sample_result,
    input wire logic ch0_high_q,
    input wire logic ch0_low_q,
    input wire logic ch1_high_q,
    input wire logic ch1_low_q,
    input wire logic irq_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire any_q = ch0_high_q | ch0_low_q | ch1_high_q | ch1_low_q;

    chk_read_idle: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
        else $error("read data not idle");
    chk_nibble_zero: assert property (reg_rd
        && reg_addr inside {8'h39, 8'h3B, 8'h3D, 8'h3F} |=> reg_rdata_q[7:4] == 4'h0)
        else $error("nibble upper bits set");
    chk_hyst_zero: assert property (reg_rd && reg_addr inside {8'h40, 8'h41}
        |=> reg_rdata_q[7:6] == 2'h0) else $error("hysteresis upper bits set");
    chk_reset_clear: assert property ($rose(rst_n) |-> !any_q && !irq_q)
        else $error("outputs not clear after reset");
    chk_ch0_high_src: assert property ($rose(ch0_high_q)
        |-> $past(sample_valid && !sample_channel, 2)) else $error("ch0 high rose unprompted");
    chk_ch1_low_src: assert property ($rose(ch1_low_q)
        |-> $past(sample_valid && sample_channel, 2)) else $error("ch1 low rose unprompted");
    // Disable may clear the state, so either cause allows a release
    chk_hold_level: assert property ($fell(ch0_high_q)
        |-> $past(sample_valid && !sample_channel, 2) || $past(reg_wr && reg_addr == 8'h37, 2)
        || $past(reg_wr && reg_addr == 8'h37, 1)) else $error("ch0 high released unprompted");
    chk_disable_clear: assert property (reg_wr && reg_addr == 8'h37 && !reg_wdata[0]
        && !sample_valid |-> ##2 !any_q) else $error("compare outputs kept after disable");
endmodule

bind window_threshold_registers window_threshold_chk #(.WIDTH(WIDTH)) chk_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sample_valid(sample_valid),
    .sample_channel(sample_channel), .sample_result(sample_result), .ch0_high_q(ch0_high_q),
    .ch0_low_q(ch0_low_q), .ch1_high_q(ch1_high_q), .ch1_low_q(ch1_low_q), .irq_q(irq_q));

// >>> verif/window_threshold_registers_bench.sv
// Self-checking bench for the window threshold register bank
// Assumes one 100 MHz clock and a synchronous active-low reset
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module window_threshold_registers_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, sample_valid = 1'b0, sample_channel = 1'b0;
    logic [11:0] sample_result = 12'h000;
    wire [7:0] reg_rdata_q;
    wire ch0_high_q, ch0_low_q, ch1_high_q, ch1_low_q, irq_q;
    wire [4:0] outs = {ch0_high_q, ch0_low_q, ch1_high_q, ch1_low_q, irq_q};
    int bad_count = 0;
    int checks_done = 0;
    // Values written to the narrow fields carry reserved bits set; reads must drop them
    row_t rows[15] = '{'{8'h37, 8'hFF, 8'h01}, '{8'h38, 8'hC3, 8'hC3}, '{8'h39, 8'hF1, 8'h01},
        '{8'h3A, 8'h3C, 8'h3C}, '{8'h3B, 8'hF0, 8'h00}, '{8'h3C, 8'h5A, 8'h5A},
        '{8'h3D, 8'hF8, 8'h08}, '{8'h3E, 8'hA5, 8'hA5}, '{8'h3F, 8'hF0, 8'h00},
        '{8'h40, 8'hD0, 8'h10}, '{8'h41, 8'hC0, 8'h00}, '{8'h42, 8'hFF, 8'h00},
        '{8'h50, 8'hFF, 8'h00}, '{8'h51, 8'hFF, 8'h0F}, '{8'h52, 8'hFF, 8'h00}};

    window_threshold_registers #(.WIDTH(12)) uut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .sample_valid(sample_valid), .sample_channel(sample_channel),
        .sample_result(sample_result), .ch0_high_q(ch0_high_q), .ch0_low_q(ch0_low_q),
        .ch1_high_q(ch1_high_q), .ch1_low_q(ch1_low_q), .irq_q(irq_q));

    always #5 clk = ~clk;

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK("read data", e, reg_rdata_q)
    endtask
    // Output lands two edges after the strobe cycle
    task smp(input logic ch, input logic [11:0] r, input logic [4:0] e);
        @(posedge clk);
        sample_valid <= 1'b1; sample_channel <= ch; sample_result <= r;
        @(posedge clk);
        sample_valid <= 1'b0;
        @(posedge clk);
        #1 `CHK("compare outputs", e, outs)
    endtask
    task irq_is(input logic e);
        @(posedge clk);
        #1 `CHK("irq", e, irq_q)
    endtask
    task print_verdict;
        if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) rd(rows[i].a, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        smp(1'b0, 12'h1C2, 5'b00000);
        smp(1'b0, 12'h1C3, 5'b10001);
        smp(1'b0, 12'h1B3, 5'b10001);
        smp(1'b0, 12'h1B2, 5'b00001);
        smp(1'b0, 12'h03C, 5'b01001);
        smp(1'b0, 12'h04C, 5'b01001);
        smp(1'b0, 12'h04D, 5'b00001);
        rd(8'h50, 8'h03);
        wr(8'h52, 8'h03);
        rd(8'h50, 8'h00);
        irq_is(1'b0);
        smp(1'b1, 12'h85A, 5'b00101);
        smp(1'b1, 12'h859, 5'b00001);
        smp(1'b1, 12'h0A5, 5'b00011);
        wr(8'h51, 8'h00);
        irq_is(1'b0);
        wr(8'h51, 8'h08);
        irq_is(1'b1);
        wr(8'h37, 8'h00);
        repeat (2) @(posedge clk);
        #1 `CHK("disabled outputs", 5'b00001, outs)
        smp(1'b1, 12'h000, 5'b00001);
        wr(8'h52, 8'h0F);
        irq_is(1'b0);
        // High limit below the hysteresis never releases
        wr(8'h37, 8'h01);
        wr(8'h39, 8'h00);
        wr(8'h38, 8'h08);
        smp(1'b0, 12'h008, 5'b11000);
        smp(1'b0, 12'h000, 5'b11000);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h3D, 8'h00);
        rd(8'h41, 8'h00);
        print_verdict();
    end
endmodule
